// file: dicct_defs.vh
// Purpose: constants for the instruction cycle timing block
// Assumes: one machine clock, counts in machine cycles
// Notes: class, space and code-location codes
`ifndef DICCT_DEFS_VH
`define DICCT_DEFS_VH
// ----------------------------------------
// instruction classes
// ----------------------------------------
`define DICCT_OP_MAC_MOVE 3'h0
`define DICCT_OP_LOAD_MAP 3'h1
`define DICCT_OP_STORE_MAP 3'h2
`define DICCT_OP_PORT_OUT 3'h3
`define DICCT_OP_PORT_IN 3'h4
`define DICCT_OP_LOAD_PROT 3'h5
`define DICCT_OP_LOAD_IMM 3'h6
// ----------------------------------------
// operand spaces
// ----------------------------------------
`define DICCT_SP_DUAL 2'h0
`define DICCT_SP_SINGLE 2'h1
`define DICCT_SP_EXT 2'h2
`define DICCT_SP_PERIPH 2'h3
// ----------------------------------------
// code location
// ----------------------------------------
`define DICCT_CODE_ROM 2'h0
`define DICCT_CODE_DUAL 2'h1
`define DICCT_CODE_SINGLE 2'h2
`define DICCT_CODE_EXT 2'h3
// ----------------------------------------
// base counts
// ----------------------------------------
`define DICCT_BASE_TWO 16'h0002
`define DICCT_BASE_THREE 16'h0003
`define DICCT_WORDS_ONE 2'h1
`define DICCT_WORDS_TWO 2'h2
`endif

// file: dicct_count_reg.v
// Purpose: registered cycle budget store for the timing block
// Assumes: single clock, async active-low reset
// Notes: holds the computed budget and the countdown
`timescale 1ns/1ps
module dicct_count_reg #(
  parameter W = 16
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_load,
  input wire [W-1:0] i_value,
  output reg [W-1:0] o_count,
  output wire o_zero
);
  // ----------------------------------------
  // countdown register
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_count <= {W{1'b0}};
    end else if (i_load) begin
      o_count <= i_value;
    end else if (o_count != {W{1'b0}}) begin
      o_count <= o_count - {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign o_zero = (o_count == {W{1'b0}});
endmodule // dicct_count_reg

// file: dicct_timing.v
// Purpose: cycle-count sequencer for mac, mapped-register, port and load classes
// Assumes: issue inputs come from logic on I_CLK_SYS; wait states are per-space counts
// Notes: busy spans the whole computed count; one issue at a time
// What this block does
// - one-word direct mac-with-move takes two cycles
// - external operand2 skips the data move
// - both operands one single block: 3, 3n-1
// - operands and code one block: 4, 3n+1
// - operand2 with code repeated: 2n+1
// - load mapped two words, 2 or 2n
// - peripheral destination once adds one cycle
// - peripheral destination repeated adds n cycles
// - store mapped two words, 2 or 2n
// - peripheral source once adds one cycle
// - port out: 3+wait or 3n+n*wait
// - port in: 2+wait or 2n+n*wait
// - protected loads two cycles, 2n repeated
// - immediate loads two cycles, never repeated
// - source with code in block adds cycle
// - destination with code in block adds cycles
`timescale 1ns/1ps
`include "dicct_defs.vh"
module dicct_timing #(
  parameter CW = 16,
  parameter RW = 8,
  parameter WW = 4
) (
  input wire I_CLK_SYS,
  input wire I_RST_N,
  input wire I_ISSUE,
  input wire [2:0] I_OPCLASS,
  input wire [1:0] I_SPACE_A,
  input wire [1:0] I_SPACE_B,
  input wire I_SAME_BLOCK_AB,
  input wire I_SAME_BLOCK_A_CODE,
  input wire I_SAME_BLOCK_B_CODE,
  input wire [1:0] I_CODE_LOC,
  input wire I_REPEAT,
  input wire [RW-1:0] I_REPEAT_N,
  input wire [WW-1:0] I_WAIT_DATA,
  input wire [WW-1:0] I_WAIT_PROG,
  input wire [WW-1:0] I_WAIT_PORT,
  output wire O_READY,
  output reg O_BUSY,
  output reg O_DONE,
  output reg O_REJECT,
  output reg O_MOVE_EN,
  output reg [1:0] O_WORDS,
  output reg [CW-1:0] O_CYCLES
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [CW-1:0] next_cycles;
  reg next_move;
  reg [1:0] next_words;
  reg next_bad;
  wire [CW-1:0] cnt;
  wire cnt_zero;
  wire load;
  wire [CW-1:0] nn;
  wire [CW-1:0] wd;
  wire [CW-1:0] wp;
  wire [CW-1:0] wio;
  wire single_a;
  wire single_b;
  wire ext_a;
  wire ext_b;
  wire per_a;
  wire per_b;
  wire code_ext;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [CW-1:0] mul_n;
    input [CW-1:0] a;
    input [CW-1:0] b;
    begin
      mul_n = a * b;
    end
  endfunction
  function [CW-1:0] pick;
    input rep;
    input [CW-1:0] once;
    input [CW-1:0] many;
    begin
      pick = rep ? many : once;
    end
  endfunction
  function [CW-1:0] per_access;
    input rep;
    input [CW-1:0] n;
    input [CW-1:0] w;
    begin
      per_access = rep ? n * w : w;
    end
  endfunction
  function [CW-1:0] rep_extra;
    input rep;
    input [CW-1:0] n;
    input [CW-1:0] k;
    begin
      rep_extra = rep ? k * (n - {{(CW-1){1'b0}}, 1'b1}) : {CW{1'b0}};
    end
  endfunction
  // ----------------------------------------
  // space decode
  // ----------------------------------------
  assign nn = {{(CW-RW){1'b0}}, I_REPEAT_N};
  assign wd = {{(CW-WW){1'b0}}, I_WAIT_DATA};
  assign wp = {{(CW-WW){1'b0}}, I_WAIT_PROG};
  assign wio = {{(CW-WW){1'b0}}, I_WAIT_PORT};
  assign single_a = (I_SPACE_A == `DICCT_SP_SINGLE);
  assign single_b = (I_SPACE_B == `DICCT_SP_SINGLE);
  assign ext_a = (I_SPACE_A == `DICCT_SP_EXT);
  assign ext_b = (I_SPACE_B == `DICCT_SP_EXT);
  assign per_a = (I_SPACE_A == `DICCT_SP_PERIPH);
  assign per_b = (I_SPACE_B == `DICCT_SP_PERIPH);
  assign code_ext = (I_CODE_LOC == `DICCT_CODE_EXT);
  // ----------------------------------------
  // cycle budget
  // ----------------------------------------
  always @* begin
    next_cycles = `DICCT_BASE_TWO;
    next_move = 1'b0;
    next_words = `DICCT_WORDS_ONE;
    next_bad = 1'b0;
    case (I_OPCLASS)
      `DICCT_OP_MAC_MOVE: begin
        next_words = `DICCT_WORDS_ONE;
        next_move = !ext_b;
        if (single_a && single_b && I_SAME_BLOCK_AB && I_SAME_BLOCK_B_CODE) begin
          next_cycles = pick(I_REPEAT, 16'h0004, mul_n(nn, 16'h0003) + 16'h0001);
        end else if (single_a && single_b && I_SAME_BLOCK_AB) begin
          next_cycles = pick(I_REPEAT, 16'h0003, mul_n(nn, 16'h0003) - 16'h0001);
        end else if (single_b) begin
          if (I_SAME_BLOCK_B_CODE) begin
            next_cycles = pick(I_REPEAT, `DICCT_BASE_TWO, mul_n(nn, 16'h0002) + 16'h0001);
          end else begin
            next_cycles = pick(I_REPEAT, `DICCT_BASE_TWO, mul_n(nn, 16'h0002) - 16'h0001);
          end
          if (ext_a) begin
            next_cycles = next_cycles + per_access(I_REPEAT, nn, wp);
          end
        end else if (ext_a && ext_b) begin
          next_cycles = pick(I_REPEAT, `DICCT_BASE_THREE + wp + wd,
            mul_n(nn, 16'h0002) + 16'h0001 + mul_n(nn, wp) + mul_n(nn, wd));
        end else begin
          next_cycles = pick(I_REPEAT, `DICCT_BASE_TWO, nn + 16'h0001);
          if (ext_a) begin
            next_cycles = next_cycles + per_access(I_REPEAT, nn, wp);
          end
          if (ext_b) begin
            next_cycles = next_cycles + per_access(I_REPEAT, nn, wd);
          end
        end
        if (code_ext) begin
          next_cycles = next_cycles + wp;
        end
      end
      `DICCT_OP_LOAD_MAP: begin
        next_words = `DICCT_WORDS_TWO;
        if (per_b) begin
          next_cycles = pick(I_REPEAT, `DICCT_BASE_THREE + wio,
            mul_n(nn, 16'h0003) + mul_n(nn, wio));
          if (ext_a) begin
            next_cycles = next_cycles + rep_extra(I_REPEAT, nn, 16'h0001);
          end
        end else begin
          next_cycles = pick(I_REPEAT, `DICCT_BASE_TWO, mul_n(nn, 16'h0002));
        end
        if (I_SPACE_B == `DICCT_SP_EXT) begin
          next_cycles = next_cycles + pick(I_REPEAT, 16'h0001, nn);
        end
        if (single_a && I_SAME_BLOCK_A_CODE) begin
          next_cycles = next_cycles + 16'h0001;
        end
        if (ext_a) begin
          next_cycles = next_cycles + pick(I_REPEAT, wd, mul_n(nn, wd));
        end
      end
      `DICCT_OP_STORE_MAP: begin
        next_words = `DICCT_WORDS_TWO;
        next_cycles = pick(I_REPEAT, `DICCT_BASE_TWO, mul_n(nn, 16'h0002));
        if (I_SPACE_A == `DICCT_SP_EXT) begin
          next_cycles = next_cycles + pick(I_REPEAT, 16'h0001, nn);
        end
        if (per_a) begin
          next_cycles = next_cycles + pick(I_REPEAT, 16'h0001, 16'h0000) +
            per_access(I_REPEAT, nn, wio);
        end
        if (single_b && I_SAME_BLOCK_B_CODE) begin
          next_cycles = next_cycles + pick(I_REPEAT, 16'h0001, 16'h0002);
        end
        if (ext_b) begin
          next_cycles = next_cycles + pick(I_REPEAT, 16'h0001 + wd, nn + mul_n(nn, wd));
          if (per_a) begin
            next_cycles = next_cycles + rep_extra(I_REPEAT, nn, 16'h0002);
          end
        end
      end
      `DICCT_OP_PORT_OUT: begin
        next_words = `DICCT_WORDS_TWO;
        next_cycles = pick(I_REPEAT, `DICCT_BASE_THREE + wio,
          mul_n(nn, 16'h0003) + mul_n(nn, wio));
        if (single_a && I_SAME_BLOCK_A_CODE) begin
          next_cycles = next_cycles + 16'h0001;
        end
        if (ext_a) begin
          next_cycles = next_cycles + pick(I_REPEAT, wd, mul_n(nn, wd));
          next_cycles = next_cycles + rep_extra(I_REPEAT, nn, 16'h0002);
        end
      end
      `DICCT_OP_PORT_IN: begin
        next_words = `DICCT_WORDS_TWO;
        next_cycles = pick(I_REPEAT, `DICCT_BASE_TWO + wio,
          mul_n(nn, 16'h0002) + mul_n(nn, wio));
        if (single_b && I_SAME_BLOCK_B_CODE) begin
          next_cycles = next_cycles + pick(I_REPEAT, 16'h0001, 16'h0002);
        end
        if (ext_b) begin
          next_cycles = next_cycles + pick(I_REPEAT, 16'h0001 + wd, nn + mul_n(nn, wd));
          next_cycles = next_cycles + rep_extra(I_REPEAT, nn, 16'h0001);
        end
      end
      `DICCT_OP_LOAD_PROT: begin
        next_cycles = pick(I_REPEAT, `DICCT_BASE_TWO, mul_n(nn, 16'h0002));
        if (single_a && I_SAME_BLOCK_A_CODE) begin
          next_cycles = next_cycles + 16'h0001;
        end
        if (ext_a) begin
          next_cycles = next_cycles + pick(I_REPEAT, wd, mul_n(nn, wd));
        end
      end
      `DICCT_OP_LOAD_IMM: begin
        next_cycles = `DICCT_BASE_TWO;
        next_bad = I_REPEAT;
      end
      default: begin
        next_bad = 1'b1;
      end
    endcase
    if (code_ext && I_OPCLASS != `DICCT_OP_MAC_MOVE) begin
      next_cycles = next_cycles + mul_n({{(CW-2){1'b0}}, next_words}, wp);
    end
    if (I_REPEAT && I_REPEAT_N == {RW{1'b0}}) begin
      next_bad = 1'b1;
    end
  end
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  assign O_READY = (state == ST_IDLE);
  assign load = O_READY && I_ISSUE && !next_bad;
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (load) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cnt == {{(CW-1){1'b0}}, 1'b1} || cnt_zero) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end
  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state <= ST_IDLE;
      O_BUSY <= 1'b0;
      O_DONE <= 1'b0;
      O_REJECT <= 1'b0;
      O_MOVE_EN <= 1'b0;
      O_WORDS <= 2'h0;
      O_CYCLES <= {CW{1'b0}};
    end else begin
      state <= next_state;
      O_BUSY <= (next_state == ST_RUN);
      O_DONE <= (state == ST_RUN) && (next_state == ST_IDLE);
      O_REJECT <= O_READY && I_ISSUE && next_bad;
      if (load) begin
        O_MOVE_EN <= next_move;
        O_WORDS <= next_words;
        O_CYCLES <= next_cycles;
      end
    end
  end
  dicct_count_reg #(
    .W(CW)
  ) u_count (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_load(load),
    .i_value(next_cycles),
    .o_count(cnt),
    .o_zero(cnt_zero)
  );
endmodule // dicct_timing

// file: dicct_timing_monitor.sv
// Purpose: concurrent checks on the cycle timing block ports
// Assumes: one clock, async active-low reset
// Notes: bound to every dicct_timing instance below
`timescale 1ns/1ps
`include "dicct_defs.vh"
module dicct_timing_monitor #(
  parameter CW = 16,
  parameter RW = 8,
  parameter WW = 4
) (
  input wire I_CLK_SYS,
  input wire I_RST_N,
  input wire I_ISSUE,
  input wire [2:0] I_OPCLASS,
  input wire [1:0] I_SPACE_A,
  input wire [1:0] I_SPACE_B,
  input wire I_SAME_BLOCK_AB,
  input wire I_SAME_BLOCK_A_CODE,
  input wire I_SAME_BLOCK_B_CODE,
  input wire [1:0] I_CODE_LOC,
  input wire I_REPEAT,
  input wire [RW-1:0] I_REPEAT_N,
  input wire [WW-1:0] I_WAIT_DATA,
  input wire [WW-1:0] I_WAIT_PROG,
  input wire [WW-1:0] I_WAIT_PORT,
  input wire O_READY,
  input wire O_BUSY,
  input wire O_DONE,
  input wire O_REJECT,
  input wire O_MOVE_EN,
  input wire [1:0] O_WORDS,
  input wire [CW-1:0] O_CYCLES
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  wire take = O_READY && I_ISSUE;
  wire rom = I_CODE_LOC == `DICCT_CODE_ROM;
  wire once_t = take && rom && !I_REPEAT;
  wire rep_t = take && rom && I_REPEAT && I_REPEAT_N != {RW{1'b0}};
  wire a0 = I_SPACE_A == `DICCT_SP_DUAL;
  wire b0 = I_SPACE_B == `DICCT_SP_DUAL;
  reg [CW-1:0] cnt;
  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) cnt <= {CW{1'b0}};
    else if (take) cnt <= {CW{1'b0}};
    else cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
  end
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_done_at_count: assert property (O_DONE |-> cnt == O_CYCLES)
    else $error("done not at computed count");
  chk_busy_not_ready: assert property (O_BUSY |-> !O_READY && !O_DONE)
    else $error("ready or done while busy");
  chk_mac_plain: assert property (once_t && I_OPCLASS == `DICCT_OP_MAC_MOVE && a0 && b0
    |=> O_CYCLES == `DICCT_BASE_TWO && O_WORDS == `DICCT_WORDS_ONE && O_MOVE_EN)
    else $error("mac with move not two cycles");
  chk_ext_no_move: assert property ((once_t || rep_t) && I_OPCLASS == `DICCT_OP_MAC_MOVE
    && I_SPACE_B == `DICCT_SP_EXT |=> !O_MOVE_EN) else $error("move done with ext operand");
  chk_imm_refused: assert property (take && I_OPCLASS == `DICCT_OP_LOAD_IMM && I_REPEAT
    |=> O_REJECT && !O_BUSY) else $error("repeated immediate load accepted");
  chk_prot_repeat: assert property (rep_t && I_OPCLASS == `DICCT_OP_LOAD_PROT && a0
    |=> O_CYCLES == {$past(I_REPEAT_N), 1'b0}) else $error("protected load not 2n");
  chk_map_repeat: assert property (rep_t && a0 && b0 && (I_OPCLASS == `DICCT_OP_LOAD_MAP
    || I_OPCLASS == `DICCT_OP_STORE_MAP) |=> O_CYCLES == {$past(I_REPEAT_N), 1'b0})
    else $error("mapped move not 2n");
  chk_out_once: assert property (once_t && I_OPCLASS == `DICCT_OP_PORT_OUT && a0
    && I_SPACE_B == `DICCT_SP_PERIPH |=> O_CYCLES == `DICCT_BASE_THREE + $past(I_WAIT_PORT))
    else $error("port out count wrong");
  chk_in_repeat: assert property (rep_t && I_OPCLASS == `DICCT_OP_PORT_IN && b0
    && I_SPACE_A == `DICCT_SP_PERIPH
    |=> O_CYCLES == $past(I_REPEAT_N) * (`DICCT_BASE_TWO + $past(I_WAIT_PORT)))
    else $error("port in repeat count wrong");
  cov_mac_repeat: cover property (rep_t && I_OPCLASS == `DICCT_OP_MAC_MOVE);
  cov_refused: cover property (O_REJECT);
  cov_back_to_back: cover property (O_DONE && take);
endmodule // dicct_timing_monitor
bind dicct_timing dicct_timing_monitor #(.CW(CW), .RW(RW), .WW(WW)) i_dicct_timing_monitor (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_ISSUE(I_ISSUE), .I_OPCLASS(I_OPCLASS),
  .I_SPACE_A(I_SPACE_A), .I_SPACE_B(I_SPACE_B), .I_SAME_BLOCK_AB(I_SAME_BLOCK_AB),
  .I_SAME_BLOCK_A_CODE(I_SAME_BLOCK_A_CODE), .I_SAME_BLOCK_B_CODE(I_SAME_BLOCK_B_CODE),
  .I_CODE_LOC(I_CODE_LOC), .I_REPEAT(I_REPEAT), .I_REPEAT_N(I_REPEAT_N),
  .I_WAIT_DATA(I_WAIT_DATA), .I_WAIT_PROG(I_WAIT_PROG), .I_WAIT_PORT(I_WAIT_PORT),
  .O_READY(O_READY), .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_REJECT(O_REJECT),
  .O_MOVE_EN(O_MOVE_EN), .O_WORDS(O_WORDS), .O_CYCLES(O_CYCLES));

// file: dicct_timing_bench.sv
// Purpose: self-checking bench for the cycle timing block
// Assumes: inputs driven at the falling edge
// Notes: expected results queued by the driver, checked at done or reject
`timescale 1ns/1ps
module dicct_timing_bench;
  reg I_CLK_SYS, I_RST_N, I_ISSUE, I_SAME_BLOCK_AB, I_SAME_BLOCK_A_CODE, I_SAME_BLOCK_B_CODE;
  reg I_REPEAT;
  reg [2:0] I_OPCLASS;
  reg [1:0] I_SPACE_A, I_SPACE_B, I_CODE_LOC;
  reg [7:0] I_REPEAT_N;
  reg [3:0] I_WAIT_DATA, I_WAIT_PROG, I_WAIT_PORT;
  wire O_READY, O_BUSY, O_DONE, O_REJECT, O_MOVE_EN;
  wire [1:0] O_WORDS;
  wire [15:0] O_CYCLES;
  integer fails = 0, comparisons = 0, tests = 0, seed = 76095, r, n, w, i;
  reg [19:0] exp_q[$];
  reg [19:0] got, x;
  always #20 I_CLK_SYS = ~I_CLK_SYS;
  dicct_timing i_dicct_timing (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_ISSUE(I_ISSUE),
    .I_OPCLASS(I_OPCLASS), .I_SPACE_A(I_SPACE_A), .I_SPACE_B(I_SPACE_B),
    .I_SAME_BLOCK_AB(I_SAME_BLOCK_AB), .I_SAME_BLOCK_A_CODE(I_SAME_BLOCK_A_CODE),
    .I_SAME_BLOCK_B_CODE(I_SAME_BLOCK_B_CODE), .I_CODE_LOC(I_CODE_LOC), .I_REPEAT(I_REPEAT),
    .I_REPEAT_N(I_REPEAT_N), .I_WAIT_DATA(I_WAIT_DATA), .I_WAIT_PROG(I_WAIT_PROG),
    .I_WAIT_PORT(I_WAIT_PORT), .O_READY(O_READY), .O_BUSY(O_BUSY), .O_DONE(O_DONE),
    .O_REJECT(O_REJECT), .O_MOVE_EN(O_MOVE_EN), .O_WORDS(O_WORDS), .O_CYCLES(O_CYCLES));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task report_and_stop;
    begin
      if (exp_q.size() != 0) fails = fails + 1;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task check(input [15:0] seen, input [15:0] want, input string nm);
    begin
      comparisons = comparisons + 1;
      if (seen !== want) begin
        fails = fails + 1;
        $display("mismatch %s expected %0h seen %0h", nm, want, seen);
      end
    end
  endtask
  // e holds check-move, move, words and cycles; cycles zero means refused
  task automatic go(input [2:0] op, input [1:0] a, input [1:0] b, input [2:0] sb,
    input [1:0] cl, input rp, input [7:0] rn, input [3:0] wd, input [3:0] wq, input [19:0] e);
    integer k;
    begin
      r = $random(seed);
      {I_OPCLASS, I_SPACE_A, I_SPACE_B, I_CODE_LOC, I_REPEAT, I_REPEAT_N} = {op, a, b, cl, rp, rn};
      {I_SAME_BLOCK_AB, I_SAME_BLOCK_A_CODE, I_SAME_BLOCK_B_CODE} = sb;
      {I_WAIT_DATA, I_WAIT_PROG, I_WAIT_PORT} = {wd, r[3:0], wq};
      // program wait once per code word, external mac operand1 once per access
      if (cl == 2'h3) e[15:0] = e[15:0] + e[17:16] * r[3:0];
      if (op == 3'h0 && a == 2'h2) e[15:0] = e[15:0] + (rp ? rn : 8'h01) * r[3:0];
      I_ISSUE = 1'b1;
      exp_q.push_back(e);
      @(negedge I_CLK_SYS);
      I_ISSUE = 1'b0;
      @(negedge I_CLK_SYS);
      for (k = 0; k < 300 && O_BUSY !== 1'b0; k = k + 1) @(negedge I_CLK_SYS);
      if (k == 300) begin
        fails = fails + 1;
        report_and_stop;
      end
      tests = tests + 1;
      $display("test %0d ended", tests);
    end
  endtask
  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(negedge I_CLK_SYS) begin
    if (O_DONE === 1'b1 || O_REJECT === 1'b1) begin
      if (exp_q.size() == 0) check(16'h0000, 16'h0001, "extra result");
      else begin
        got = exp_q.pop_front();
        check({15'h0, O_REJECT}, {15'h0, got[15:0] == 16'h0000}, "reject");
        check({15'h0, O_READY}, 16'h0001, "ready");
        if (got[15:0] != 16'h0000) begin
          check(O_CYCLES, got[15:0], "cycles");
          check({14'h0, O_WORDS}, {14'h0, got[17:16]}, "words");
          if (got[19]) check({15'h0, O_MOVE_EN}, {15'h0, got[18]}, "move");
        end
      end
    end
  end
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    {I_CLK_SYS, I_RST_N, I_ISSUE, I_SAME_BLOCK_AB, I_SAME_BLOCK_A_CODE, I_SAME_BLOCK_B_CODE,
      I_REPEAT, I_OPCLASS, I_SPACE_A, I_SPACE_B, I_CODE_LOC, I_REPEAT_N, I_WAIT_DATA,
      I_WAIT_PROG, I_WAIT_PORT} = 36'h0;
    repeat (6) @(negedge I_CLK_SYS);
    I_RST_N = 1'b1;
    go(3'h0, 2'h0, 2'h0, 3'h0, 2'h0, 1'b0, 8'h01, 4'h0, 4'h0, 20'hD0002);
    go(3'h0, 2'h0, 2'h2, 3'h0, 2'h0, 1'b0, 8'h01, 4'h3, 4'h0, 20'h90005);
    go(3'h0, 2'h1, 2'h2, 3'h0, 2'h0, 1'b1, 8'h04, 4'h2, 4'h0, 20'h9000D);
    go(3'h0, 2'h1, 2'h1, 3'h4, 2'h0, 1'b0, 8'h01, 4'h0, 4'h0, 20'hD0003);
    go(3'h0, 2'h1, 2'h1, 3'h4, 2'h0, 1'b1, 8'h04, 4'h0, 4'h0, 20'hD000B);
    go(3'h0, 2'h1, 2'h1, 3'h7, 2'h2, 1'b0, 8'h01, 4'h0, 4'h0, 20'hD0004);
    go(3'h0, 2'h1, 2'h1, 3'h7, 2'h2, 1'b1, 8'h03, 4'h0, 4'h0, 20'hD000A);
    go(3'h0, 2'h0, 2'h1, 3'h1, 2'h2, 1'b1, 8'h03, 4'h0, 4'h0, 20'hD0007);
    go(3'h1, 2'h0, 2'h0, 3'h0, 2'h0, 1'b0, 8'h01, 4'h0, 4'h0, 20'h20002);
    go(3'h1, 2'h0, 2'h0, 3'h0, 2'h0, 1'b1, 8'h05, 4'h0, 4'h0, 20'h2000A);
    go(3'h1, 2'h0, 2'h2, 3'h0, 2'h0, 1'b0, 8'h01, 4'h0, 4'h0, 20'h20003);
    go(3'h1, 2'h0, 2'h2, 3'h0, 2'h0, 1'b1, 8'h05, 4'h0, 4'h0, 20'h2000F);
    go(3'h2, 2'h2, 2'h0, 3'h0, 2'h0, 1'b1, 8'h04, 4'h0, 4'h0, 20'h2000C);
    go(3'h2, 2'h0, 2'h0, 3'h0, 2'h0, 1'b0, 8'h01, 4'h0, 4'h0, 20'h20002);
    go(3'h2, 2'h0, 2'h0, 3'h0, 2'h0, 1'b1, 8'h07, 4'h0, 4'h0, 20'h2000E);
    go(3'h2, 2'h2, 2'h0, 3'h0, 2'h0, 1'b0, 8'h01, 4'h0, 4'h0, 20'h20003);
    go(3'h3, 2'h0, 2'h3, 3'h0, 2'h0, 1'b0, 8'h01, 4'h0, 4'h2, 20'h20005);
    go(3'h3, 2'h0, 2'h3, 3'h0, 2'h0, 1'b1, 8'h03, 4'h0, 4'h2, 20'h2000F);
    go(3'h4, 2'h3, 2'h0, 3'h0, 2'h0, 1'b0, 8'h01, 4'h0, 4'h2, 20'h20004);
    go(3'h5, 2'h0, 2'h0, 3'h0, 2'h0, 1'b0, 8'h01, 4'h0, 4'h0, 20'h10002);
    go(3'h5, 2'h0, 2'h0, 3'h0, 2'h0, 1'b1, 8'h06, 4'h0, 4'h0, 20'h1000C);
    go(3'h5, 2'h0, 2'h0, 3'h0, 2'h0, 1'b1, 8'h00, 4'h0, 4'h0, 20'h00000);
    go(3'h6, 2'h0, 2'h0, 3'h0, 2'h0, 1'b0, 8'h01, 4'h0, 4'h0, 20'h10002);
    go(3'h6, 2'h0, 2'h0, 3'h0, 2'h0, 1'b1, 8'h02, 4'h0, 4'h0, 20'h00000);
    go(3'h5, 2'h1, 2'h0, 3'h2, 2'h2, 1'b0, 8'h01, 4'h0, 4'h0, 20'h10003);
    go(3'h1, 2'h1, 2'h0, 3'h2, 2'h2, 1'b0, 8'h01, 4'h0, 4'h0, 20'h20003);
    go(3'h2, 2'h0, 2'h1, 3'h1, 2'h2, 1'b0, 8'h01, 4'h0, 4'h0, 20'h20003);
    go(3'h4, 2'h3, 2'h1, 3'h1, 2'h2, 1'b1, 8'h02, 4'h0, 4'h1, 20'h20008);
    go(3'h1, 2'h0, 2'h3, 3'h0, 2'h0, 1'b0, 8'h01, 4'h0, 4'h1, 20'h20004);
    go(3'h1, 2'h0, 2'h3, 3'h0, 2'h0, 1'b1, 8'h02, 4'h0, 4'h1, 20'h20008);
    go(3'h0, 2'h0, 2'h0, 3'h0, 2'h3, 1'b0, 8'h01, 4'h0, 4'h0, 20'hD0002);
    go(3'h1, 2'h0, 2'h0, 3'h0, 2'h3, 1'b1, 8'h03, 4'h0, 4'h0, 20'h20006);
    go(3'h0, 2'h2, 2'h1, 3'h0, 2'h0, 1'b1, 8'h03, 4'h0, 4'h0, 20'hD0005);
    go(3'h4, 2'h3, 2'h2, 3'h0, 2'h0, 1'b1, 8'h02, 4'h1, 4'h1, 20'h2000B);
    for (i = 0; i < 4; i = i + 1) begin
      n = 1 + ($random(seed) & 7);
      w = $random(seed) & 15;
      x = n * (2 + w);
      go(3'h4, 2'h3, 2'h0, 3'h0, 2'h0, 1'b1, n[7:0], 4'h0, w[3:0], {4'h2, x[15:0]});
    end
    repeat (3) @(negedge I_CLK_SYS);
    report_and_stop;
  end
endmodule // dicct_timing_bench
